/* File: core/tmc_top.sv */
// Top: Avalon-MM slave, timer zero, timer one, PWM unit, pin routing and
// a global interrupt status/clear/enable group.
// Assumes a single synchronous clock; pins are synchronous levels.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"
module tmc_top (
   input wire logic sys_clk_in, // 100 MHz system clock
   input wire logic rst_n_in, // Async reset, active low
   input wire logic [7:0] avs_address_in, // Word address
   input wire logic avs_read_in, // Read strobe
   input wire logic avs_write_in, // Write strobe
   input wire logic [31:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Byte lanes
   output logic [31:0] avs_readdata_out, // Read data
   output logic avs_waitrequest_out, // Stall
   input wire logic [31:0] p0_in, // Port 0 pin levels
   output logic [31:0] p0_out, // Port 0 alt-function outputs
   output logic [31:0] p0_oe_out, // Port 0 alt-function drive enables
   output logic [3:0] t0_match_out, // Timer zero match outputs
   output logic [3:0] pwm_match_out, // PWM unit match outputs
   output logic irq_out // Level interrupt
);
   import tmc_pkg::*;
   tmc_unit_if uif [3] ();
   tmc_bus_state_t st_q;
   logic [31:0] psel_q;
   logic [2:0] gstat_q, gen_q;
   logic [7:0] boff;
   logic [31:0] wmask;
   logic acc, wr_go;
   logic [3:0] t0_m, pw_m, t1_cap;
   logic [2:0] irqs;
   logic [31:0] rd;
   logic [3:0] t0_cap, pw_cap;
   // Byte offset inside a 16-word window
   assign boff = {2'b00, avs_address_in[3:0], 2'b00};
   assign acc = avs_read_in | avs_write_in;
   assign wr_go = avs_write_in && st_q == TMC_BUS_IDLE;
   always_comb begin
      for (int b = 0; b < 4; b++)
         wmask[8*b +: 8] = {8{avs_byteenable_in[b]}};
   end
   // One wait state: request accepted in idle, answered next edge
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) st_q <= TMC_BUS_IDLE;
      else begin
         unique case (st_q)
            TMC_BUS_IDLE: if (acc) st_q <= TMC_BUS_ACK;
            TMC_BUS_ACK: st_q <= TMC_BUS_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         avs_waitrequest_out <= !(acc && st_q == TMC_BUS_IDLE);
         if (avs_read_in && st_q == TMC_BUS_IDLE) avs_readdata_out <= rd;
      end
   end
   // Unit access: word addresses 0x00..0x2F form three 16-word windows;
   // words from 0x40 up select nothing, so writes there are dropped
   for (genvar u = 0; u < 3; u++) begin : g_bus
      assign uif[u].wr = wr_go && avs_address_in[7:4] == 4'(u);
      assign uif[u].off = boff;
      assign uif[u].wdata = avs_writedata_in & wmask;
      assign irqs[u] = uif[u].irq;
   end
   // Read mux; unmapped reads return zero
   always_comb begin
      unique case (avs_address_in[7:4])
         4'h0: rd = uif[0].rdata;
         4'h1: rd = uif[1].rdata;
         4'h2: rd = uif[2].rdata;
         4'h3: begin
            rd = `TMC_READ_UNMAPPED;
            if (boff == `TMC_OFF_PIN_FUNCTION_SELECT - 8'hC0) rd = psel_q;
            if (boff == `TMC_OFF_GSTAT - 8'hC0) rd = {29'h0, gstat_q};
            if (boff == `TMC_OFF_GEN - 8'hC0) rd = {29'h0, gen_q};
         end
         default: rd = `TMC_READ_UNMAPPED;
      endcase
   end
   // Pin-function select and global interrupt group; set wins over clear
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         psel_q <= `TMC_PSEL_RESET;
         gstat_q <= 3'h0;
         gen_q <= 3'h0;
         irq_out <= 1'b0;
      end else begin
         if (wr_go && avs_address_in == 8'(`TMC_OFF_PIN_FUNCTION_SELECT >> 2))
            psel_q <= (psel_q & ~wmask) | (avs_writedata_in & wmask);
         if (wr_go && avs_address_in == 8'(`TMC_OFF_GEN >> 2))
            gen_q <= avs_writedata_in[2:0];
         if (wr_go && avs_address_in == 8'(`TMC_OFF_GCLR >> 2))
            gstat_q <= (gstat_q & ~avs_writedata_in[2:0]) | irqs;
         else
            gstat_q <= gstat_q | irqs;
         irq_out <= |(gstat_q & gen_q);
      end
   end
   // Capture routing: each select field acts on its own pin only
   assign t1_cap = {p0_in[21] & (psel_q[`TMC_PSEL_P0_21] == `TMC_PSEL_ALT),
      p0_in[19] & (psel_q[`TMC_PSEL_P0_19] == `TMC_PSEL_ALT), 2'b00};
   assign t0_cap = 4'h0;
   assign pw_cap = 4'h0;
   tmc_unit #(.CHANNELS(4)) u_t0 (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .bus(uif[0]), .cap_in(t0_cap), .match_out(t0_m));
   tmc_unit #(.CHANNELS(4)) u_t1 (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .bus(uif[1]), .cap_in(t1_cap), .match_out());
   tmc_unit #(.CHANNELS(4)) u_pwm (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .bus(uif[2]), .cap_in(pw_cap), .match_out(pw_m));
   // Match pin routing, registered so outputs come from flip-flops
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         p0_out <= 32'h0000_0000;
         p0_oe_out <= 32'h0000_0000;
         t0_match_out <= 4'h0;
         pwm_match_out <= 4'h0;
      end else begin
         t0_match_out <= t0_m;
         pwm_match_out <= pw_m;
         p0_out <= 32'h0000_0000;
         p0_oe_out <= 32'h0000_0000;
         p0_out[3] <= t0_m[0];
         p0_oe_out[3] <= psel_q[`TMC_PSEL_P0_3] == `TMC_PSEL_ALT;
         p0_out[22] <= t0_m[0];
         p0_oe_out[22] <= psel_q[`TMC_PSEL_P0_22] == `TMC_PSEL_ALT;
         p0_out[5] <= t0_m[1];
         p0_oe_out[5] <= psel_q[`TMC_PSEL_P0_5] == `TMC_PSEL_ALT;
         p0_out[27] <= t0_m[1];
         p0_oe_out[27] <= psel_q[`TMC_PSEL_P0_27] == `TMC_PSEL_ALT;
      end
   end
   property p_cap3_route;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      psel_q[11:10] == 2'h3 |-> t1_cap[3] == p0_in[21];
   endproperty
   a_cap3_route: assert property (p_cap3_route) else $error("cap3 route");
   property p_cap2_route;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      psel_q[7:6] == 2'h3 |-> t1_cap[2] == p0_in[19];
   endproperty
   a_cap2_route: assert property (p_cap2_route) else $error("cap2 route");
   property p_p5_m1;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      1'b1 |=> p0_out[5] == $past(t0_m[1]);
   endproperty
   a_p5_m1: assert property (p_p5_m1) else $error("p0.5 wrong");
   property p_irq;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      |(gstat_q & gen_q) |=> irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq low");
   c_irq: cover property (@(posedge sys_clk_in) irq_out);
   c_wr: cover property (@(posedge sys_clk_in) wr_go);
   c_cap: cover property (@(posedge sys_clk_in) |t1_cap);
endmodule : tmc_top
`default_nettype wire

/* File: include/tmc_defines.svh */
// Register offsets, field positions, reset values and pin-select codes
// for the dual timer with match/capture interrupt flags.
// Assumes Avalon-MM word addressing on a 32-bit bus (byte offsets given).
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// Per-unit register offsets (byte) and unit stride
`define TMC_OFF_FLAG 8'h00
`define TMC_OFF_CTRL 8'h04
`define TMC_OFF_COUNT 8'h08
`define TMC_OFF_IEN 8'h0C
`define TMC_OFF_MATCH0 8'h10
`define TMC_OFF_CAP0 8'h20
`define TMC_UNIT_STRIDE 8'h40
// Global registers
`define TMC_OFF_PIN_FUNCTION_SELECT 8'hC0
`define TMC_OFF_GSTAT 8'hC4
`define TMC_OFF_GCLR 8'hC8
`define TMC_OFF_GEN 8'hCC
// Control register fields
`define TMC_CTRL_RUN 0
`define TMC_CTRL_RESET 1
// Flag layout: match bits 3:0, capture bits 7:4
`define TMC_FLAG_CAP_LSB 4
// Pin-select field positions and the alternate-function (capture or match) code
`define TMC_PSEL_P0_3 1:0
`define TMC_PSEL_P0_5 3:2
`define TMC_PSEL_P0_19 7:6
`define TMC_PSEL_P0_21 11:10
`define TMC_PSEL_P0_22 13:12
`define TMC_PSEL_P0_27 15:14
`define TMC_PSEL_ALT 2'h3
`define TMC_PSEL_RESET 32'h0000_0000
`define TMC_READ_UNMAPPED 32'h0000_0000
`endif

/* File: include/tmc_pkg.sv */
// Types shared by the timer flag block and its units.
// Needs nothing from its surroundings.
package tmc_pkg;
   typedef logic [31:0] tmc_word_t;
   typedef enum logic [1:0] {TMC_TIMER0, TMC_TIMER1, TMC_PWM} tmc_unit_t;
   typedef enum {TMC_BUS_IDLE, TMC_BUS_ACK} tmc_bus_state_t;
endpackage : tmc_pkg

/* File: include/tmc_unit_if.sv */
// Register access bundle between the bus front end and one timer unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tmc_unit_if;
   logic wr;
   logic [7:0] off;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic irq;
   modport ctl (output wr, output off, output wdata, input rdata, input irq);
   modport unit (input wr, input off, input wdata, output rdata,
      output irq);
endinterface : tmc_unit_if
`default_nettype wire

/* File: core/tmc_unit.sv */
// One timer (or PWM) unit: counter, four match and four capture channels,
// sticky interrupt flags with write-one-to-clear.
// Assumes capture inputs are synchronous single-cycle-or-longer levels.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"
module tmc_unit #(
   parameter int CHANNELS = 4
) (
   input wire logic clk_in, // System clock
   input wire logic rst_n_in, // Async reset, active low
   tmc_unit_if.unit bus, // Register access
   input wire logic [CHANNELS-1:0] cap_in, // Capture input levels
   output logic [CHANNELS-1:0] match_out // Match output levels
);
   import tmc_pkg::*;
   // Flag and enable registers are laid out for exactly four channels
   if (CHANNELS != 4) begin : g_bad_channels
      $error("tmc_unit supports four channels only");
   end
   logic [31:0] count_q;
   logic [1:0] ctrl_q;
   logic [7:0] flag_q;
   logic [7:0] ien_q;
   logic [31:0] match_q [CHANNELS];
   logic [31:0] cap_q [CHANNELS];
   logic [CHANNELS-1:0] cap_prev_q;
   logic [CHANNELS-1:0] hit;
   logic [CHANNELS-1:0] cap_edge;
   logic [7:0] events;
   logic run;
   assign run = ctrl_q[`TMC_CTRL_RUN] & ~ctrl_q[`TMC_CTRL_RESET];
   // Match compares against a running counter only, so a stopped counter
   // cannot raise events while software clears flags
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         hit[i] = run && (count_q == match_q[i]);
         cap_edge[i] = cap_in[i] & ~cap_prev_q[i];
      end
   end
   assign events = {cap_edge, hit};
   // Control and counter; start/stop through the run bit
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q <= 2'h0;
         count_q <= 32'h0000_0000;
      end else begin
         if (bus.wr && bus.off == `TMC_OFF_CTRL) ctrl_q <= bus.wdata[1:0];
         if (bus.wr && bus.off == `TMC_OFF_COUNT) count_q <= bus.wdata;
         else if (ctrl_q[`TMC_CTRL_RESET]) count_q <= 32'h0000_0000;
         else if (run) count_q <= count_q + 32'h0000_0001;
      end
   end
   // Match, enable, capture registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ien_q <= 8'h00;
         cap_prev_q <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            match_q[i] <= 32'hFFFF_FFFF;
            cap_q[i] <= 32'h0000_0000;
         end
      end else begin
         cap_prev_q <= cap_in;
         if (bus.wr && bus.off == `TMC_OFF_IEN) ien_q <= bus.wdata[7:0];
         for (int i = 0; i < CHANNELS; i++) begin
            if (bus.wr && bus.off == `TMC_OFF_MATCH0 + 8'(4 * i))
               match_q[i] <= bus.wdata;
            if (cap_edge[i]) cap_q[i] <= count_q;
         end
      end
   end
   // Sticky flags: set beats clear so a coincident event is never lost
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_q <= 8'h00;
      end else begin
         if (bus.wr && bus.off == `TMC_OFF_FLAG)
            flag_q <= (flag_q & ~bus.wdata[7:0]) | events;
         else
            flag_q <= flag_q | events;
      end
   end
   // Match outputs follow a toggle on each match
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) match_out <= '0;
      else match_out <= match_out ^ hit;
   end
   assign bus.irq = |(flag_q & ien_q);
   // Read mux
   always_comb begin
      bus.rdata = 32'h0000_0000;
      unique case (bus.off)
         `TMC_OFF_FLAG: bus.rdata = {24'h000000, flag_q};
         `TMC_OFF_CTRL: bus.rdata = {30'h0, ctrl_q};
         `TMC_OFF_COUNT: bus.rdata = count_q;
         `TMC_OFF_IEN: bus.rdata = {24'h000000, ien_q};
         default: begin
            for (int i = 0; i < CHANNELS; i++) begin
               if (bus.off == `TMC_OFF_MATCH0 + 8'(4 * i))
                  bus.rdata = match_q[i];
               if (bus.off == `TMC_OFF_CAP0 + 8'(4 * i))
                  bus.rdata = cap_q[i];
            end
         end
      endcase
   end
   // A write of one to a flag and a same-cycle event leaves it set
   property p_set_wins;
      @(posedge clk_in) disable iff (!rst_n_in)
      events[1] |=> flag_q[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");
   property p_flag_sticky;
      @(posedge clk_in) disable iff (!rst_n_in)
      flag_q[0] && !(bus.wr && bus.off == `TMC_OFF_FLAG && bus.wdata[0])
      |=> flag_q[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
   property p_clear_one;
      @(posedge clk_in) disable iff (!rst_n_in)
      bus.wr && bus.off == `TMC_OFF_FLAG && bus.wdata[0] && !events[0]
      |=> !flag_q[0];
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("no clear");
   property p_cap_load;
      @(posedge clk_in) disable iff (!rst_n_in)
      cap_edge[3] |=> cap_q[3] == $past(count_q);
   endproperty
   a_cap_load: assert property (p_cap_load) else $error("capture bad");
   property p_stop;
      @(posedge clk_in) disable iff (!rst_n_in)
      !ctrl_q[`TMC_CTRL_RUN] && !ctrl_q[`TMC_CTRL_RESET] && !bus.wr
      |=> $stable(count_q);
   endproperty
   a_stop: assert property (p_stop) else $error("counter ran");
   c_two_match: cover property (@(posedge clk_in) hit[0] ##[1:4] hit[1]);
endmodule : tmc_unit
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the dual timer block with sticky event flags.
// Drives the Avalon-MM slave and the port pins itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, rd, wr, waitreq, irq;
   logic [7:0] addr, b;
   logic [31:0] wdata, rdata, p0, p0_o, p0_oe, v, w;
   logic [3:0] t0m, pwm_m;
   int n_fail = 0;
   int n_tests = 0;

   tmc_top u_dut (
      .sys_clk_in(clk),
      .rst_n_in(rst_n),
      .avs_address_in(addr),
      .avs_read_in(rd),
      .avs_write_in(wr),
      .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq),
      .p0_in(p0),
      .p0_out(p0_o),
      .p0_oe_out(p0_oe),
      .t0_match_out(t0m),
      .pwm_match_out(pwm_m),
      .irq_out(irq)
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   // One bus cycle; request held until waitrequest is seen low
   task automatic access(input logic we, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= we;
      rd <= !we;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdata;
      if (n >= 50) begin
         n_fail++;
         $display("unexpected at %0t: no bus answer", $time);
      end
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : access

   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      access(1'b1, a, d, q);
   endtask : wr32

   task automatic rd32(input logic [7:0] a, output logic [31:0] q);
      access(1'b0, a, 32'h0000_0000, q);
   endtask : rd32

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      access(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask : rd_chk

   // Pin pulse long enough for any input synchroniser
   task automatic pulse(input int n);
      @(posedge clk);
      p0[n] <= 1'b1;
      repeat (3) @(posedge clk);
      p0[n] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // Watchdog: the sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test;
   end

   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      p0 = 32'h0000_0000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and an unmapped word
      rd_chk(8'h04, 32'hFFFF_FFFF);
      rd_chk(8'h30, 32'h0000_0000);
      wr32(8'h40, 32'hFFFF_FFFF);
      rd_chk(8'h40, 32'h0000_0000);
      wr32(8'h33, 32'h0000_0007);
      // Two close matches per unit: timer 0, timer 1, then PWM
      for (int u = 0; u < 3; u++) begin
         b = 8'(u * 16);
         rd_chk(b, 32'h0000_0000);
         wr32(b + 8'h04, 32'h0000_0005);
         wr32(b + 8'h05, 32'h0000_0006);
         wr32(b + 8'h03, 32'h0000_0003);
         wr32(b + 8'h01, 32'h0000_0001);
         repeat (20) @(posedge clk);
         rd_chk(b, 32'h0000_0003);
         rd_chk(8'h31, 32'(1 << u));
         check({31'h0, irq}, 32'h0000_0001);
         wr32(8'h33, 32'h0000_0000);
         repeat (2) @(posedge clk);
         check({31'h0, irq}, 32'h0000_0000);
         wr32(8'h33, 32'h0000_0007);
         wr32(b, 32'h0000_0001);
         rd_chk(b, 32'h0000_0002);
         wr32(b, 32'h0000_0002);
         wr32(8'h32, 32'(1 << u));
         repeat (2) @(posedge clk);
         rd_chk(8'h31, 32'h0000_0000);
         check({31'h0, irq}, 32'h0000_0000);
      end
      check({28'h0, t0m}, 32'h0000_0003);
      check({28'h0, pwm_m}, 32'h0000_0003);
      // Three consecutive matches under a stream of clear writes
      wr32(8'h04, 32'hFFFF_FFFF);
      wr32(8'h05, 32'h0000_0014);
      wr32(8'h06, 32'h0000_0015);
      wr32(8'h07, 32'h0000_0016);
      wr32(8'h03, 32'h0000_00FF);
      wr32(8'h01, 32'h0000_0002);
      wr32(8'h01, 32'h0000_0001);
      for (int i = 0; i < 20; i++) begin
         wr32(8'h00, 32'h0000_0001);
      end
      rd_chk(8'h00, 32'h0000_000E);
      check({28'h0, t0m}, 32'h0000_000D);
      // Stop, then restart the counter
      wr32(8'h01, 32'h0000_0000);
      rd32(8'h02, v);
      repeat (5) @(posedge clk);
      rd_chk(8'h02, v);
      wr32(8'h01, 32'h0000_0001);
      rd32(8'h02, w);
      check({31'h0, w != v}, 32'h0000_0001);
      // Match pins: line 5 must show output one, not output zero
      wr32(8'h30, 32'h0000_FC0F);
      repeat (3) @(posedge clk);
      check({28'h0, p0_o[27], p0_o[22], p0_o[5], p0_o[3]},
         32'h0000_0005);
      check({28'h0, p0_oe[27], p0_oe[22], p0_oe[5], p0_oe[3]},
         32'h0000_000F);
      // Capture three routed alone; line 19 not yet routed
      wr32(8'h13, 32'h0000_00F0);
      pulse(19);
      pulse(21);
      rd_chk(8'h10, 32'h0000_0080);
      rd32(8'h1B, v);
      pulse(21);
      rd32(8'h1B, w);
      check({31'h0, w != v}, 32'h0000_0001);
      wr32(8'h10, 32'h0000_0080);
      wr32(8'h30, 32'h0000_FCCF);
      pulse(19);
      rd_chk(8'h10, 32'h0000_0040);
      end_of_test;
   end
endmodule : testbench
`default_nettype wire
